//--- verilog/acp_params.svh
// Constants shared by both ends of the converter control port
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH
`define ACP_CLK_NS          10
`define ACP_CONV_NS         6000
`define ACP_CONV_CYC        ((`ACP_CONV_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_WAKE_MS         3
`define ACP_WAKE_CYC        ((`ACP_WAKE_MS * 1000000) / `ACP_CLK_NS)
`define ACP_NAP_NS          620
`define ACP_NAP_CYC         (`ACP_NAP_NS / `ACP_CLK_NS)
`define ACP_RES_W           12
`define ACP_BYTE_W          8
`define ACP_RESULT_RST      12'h000
`endif

//--- verilog/acp_pkg.sv
// Types shared by both ends of the converter control port
package acp_pkg;
    // Converter core states, Gray along idle, convert, done
    typedef enum logic [1:0] {
        ACP_IDLE = 2'b00,
        ACP_CONV = 2'b01,
        ACP_DONE = 2'b11
    } acp_state_t;
    // Host access modes
    typedef enum logic [2:0] {
        ACP_M1A  = 3'h0,
        ACP_M1B  = 3'h1,
        ACP_M2   = 3'h2,
        ACP_SLOW = 3'h3,
        ACP_ROM  = 3'h4
    } acp_mode_t;
endpackage

//--- verilog/acp_if.sv
// Pin-level link between converter and host
`timescale 1ns/100ps
`default_nettype none
interface acp_if;
    logic        cs_n;             // Chip select
    logic        rd_n;             // Read strobe
    logic        convert_start_n;  // Convert start
    logic        high_byte_select; // Byte choice
    logic        sleep_n;          // Sleep request
    logic        nap_n;            // Nap request
    logic        busy_n;           // Conversion running
    logic        reference_ready;  // Awake after sleep
    logic [11:0] data_out;         // Full 12-bit bus
    logic [7:0]  low_data_lines;   // Two-byte bus
    logic        data_oe;          // Bus driven
    modport dev  (input cs_n, rd_n, convert_start_n, high_byte_select, sleep_n, nap_n,
                  output busy_n, reference_ready, data_out, low_data_lines, data_oe);
    modport host (output cs_n, rd_n, convert_start_n, high_byte_select, sleep_n, nap_n,
                  input busy_n, reference_ready, data_out, low_data_lines, data_oe);
endinterface
`default_nettype wire

//--- verilog/acp_device.sv
// Converter end: start control, busy, read-out and power-down
`timescale 1ns/100ps
`default_nettype none
`include "acp_params.svh"
// Operating notes for the next engineer
// Start path
//   Convert start is sampled every clock and compared with its previous sample
//   Only a high-to-low step while selected counts as a request
//   A level held low never restarts; the host must lift it first
//   Requests while converting, asleep, waking or napping are dropped silently
//   There is no refusal flag, so a host must watch busy to learn the outcome
// Conversion timing
//   The timer loads the full conversion length on the start edge
//   Busy falls on that same edge and rises when the timer expires
//   One idle cycle follows each conversion before a new start is taken
//   The trade: one lost cycle of throughput for a clean restart decision
// Result path
//   The sample input is taken only in the finish cycle
//   The bus shows the held result until then, so slow readers see old data
//   The new word and the busy release change on the same clock edge
//   A host latching on the busy rise therefore always sees the new word
// Byte lanes
//   The byte bus follows the byte select one clock later
//   The upper byte carries four zero bits above the top nibble
//   A host that toggles the select must allow that extra cycle
// Bus enable
//   The enable is a registered copy of select and read both low
//   It only marks when the pins would drive; the data pins never float here
//   Shared-bus users must gate the word with the enable themselves
// Sleep
//   Sleep low drops reference ready on the next clock and blocks all starts at once
//   Releasing sleep loads the wake timer; ready rises when it expires
//   Pulsing sleep again restarts the full wake time
//   Limitation: the wake time is a count of clocks, set by a parameter
// Nap
//   Nap low blocks starts but leaves reference ready alone
//   Leaving nap holds starts off for the nap exit count
//   The exit count is rounded down to whole clocks
//   Tying reference ready to nap gives the deeper sleep saving for free
// Reset
//   The block comes out of reset awake, idle and with the bus enable low
//   Reset values are constants only, so the reset tree stays simple
// Function
// - Falling convert start with select starts conversion
// - Starts ignored while converting
// - Busy low exactly while converting
// - Byte select picks result part
// - Select and read low keep outputs driven
// - Host latches on busy rising edge
// - Host keeps convert start narrow; SLOW and ROM modes hold it low until busy rises
// - Outputs float unless read asserted; here the pins always drive and only the enable marks a read
// - Slow memory: previous result during conversion
// - Result shown then busy rises; here the word and busy release change on the same clock edge
// - ROM: strobe starts and reads previous
// - Host waits for finish in ROM
// - Sleep low blocks conversions
// - Three milliseconds wake after sleep
// - Reference ready rises after wake
// - Nap keeps only reference alive
// - Nap exit within 620 ns
// - Comparator wakes on sleep or ready
// - Conversion timed by own clock
module acp_device #(
    parameter int CONV_CYC = `ACP_CONV_CYC,
    parameter int WAKE_CYC = `ACP_WAKE_CYC,
    parameter int NAP_CYC  = `ACP_NAP_CYC
) (
    input  wire logic        MCLK,
    input  wire logic        ARST_N,
    acp_if.dev               LINK,
    input  wire logic [11:0] SAMPLE,
    output logic             CONVERTING
);
    // Core state and counters
    acp_pkg::acp_state_t state_q, state_d;
    logic [31:0] conv_cnt_q;        // Conversion timer
    logic [31:0] wake_cnt_q;        // Reference wake timer
    logic [31:0] nap_cnt_q;         // Nap exit timer
    logic        cst_q;             // Previous convert start
    logic        sleep_q;           // Previous sleep level
    logic        reference_ready_q;          // Reference ready
    logic        busy_n_q;          // Busy pin
    logic [11:0] result_q;          // Last finished result
    logic        oe_q;              // Bus enable
    logic [11:0] data_q;            // Full bus
    logic [7:0]  low_q;             // Byte bus
    logic        conv_q;            // Converting copy

    // Conversion state test, shared by busy and the status copy
    function automatic logic in_conv(input acp_pkg::acp_state_t s);
        return s == acp_pkg::ACP_CONV;
    endfunction

    // Start decode
    wire fall_cst  = cst_q & ~LINK.convert_start_n;
    wire awake     = LINK.sleep_n & reference_ready_q;
    wire nap_ok    = LINK.nap_n & (nap_cnt_q == 32'h0);
    wire start_ok  = fall_cst & ~LINK.cs_n & awake & nap_ok;
    wire finishing = (state_q == acp_pkg::ACP_CONV) && (conv_cnt_q == 32'h1);
    wire reading   = ~LINK.cs_n & ~LINK.rd_n;

    // Bus word: new sample in the finish cycle, else the held result
    wire [11:0] shown_word = finishing ? SAMPLE : result_q;
    // Byte lane choice; upper byte padded with zeros
    wire [7:0]  shown_byte = LINK.high_byte_select ? {4'h0, shown_word[11:8]} : shown_word[7:0];
    // Converting in the coming cycle
    wire        conv_next  = in_conv(state_d);

    // Next state; only IDLE takes a start, so the state guards against restarts
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            acp_pkg::ACP_IDLE: if (start_ok) state_d = acp_pkg::ACP_CONV;
            acp_pkg::ACP_CONV: if (finishing) state_d = acp_pkg::ACP_DONE;
            acp_pkg::ACP_DONE: state_d = acp_pkg::ACP_IDLE;
            default:           state_d = acp_pkg::ACP_IDLE;
        endcase
    end

    // State, timer and result register
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q    <= acp_pkg::ACP_IDLE;
            conv_cnt_q <= 32'h0;
            cst_q      <= 1'b1;
            result_q   <= `ACP_RESULT_RST;
        end else begin
            state_q <= state_d;
            cst_q   <= LINK.convert_start_n;
            if (state_q == acp_pkg::ACP_IDLE && start_ok)
                conv_cnt_q <= 32'(CONV_CYC);
            else if (conv_cnt_q != 32'h0)
                conv_cnt_q <= conv_cnt_q - 32'h1;
            // New result lands with the busy release
            if (finishing)
                result_q <= SAMPLE;
        end
    end

    // Power-down: wake timer after sleep, nap exit delay
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sleep_q    <= 1'b1;
            reference_ready_q   <= 1'b1;
            wake_cnt_q <= 32'h0;
            nap_cnt_q  <= 32'h0;
        end else begin
            sleep_q <= LINK.sleep_n;
            if (!LINK.sleep_n) begin
                reference_ready_q   <= 1'b0;
                wake_cnt_q <= 32'h0;
            end else if (!sleep_q) begin
                wake_cnt_q <= 32'(WAKE_CYC);
            end else if (wake_cnt_q > 32'h1) begin
                wake_cnt_q <= wake_cnt_q - 32'h1;
            end else if (wake_cnt_q == 32'h1) begin
                wake_cnt_q <= 32'h0;
                reference_ready_q   <= 1'b1;
            end
            // Comparator power-up delay restarts on each nap
            if (!LINK.nap_n)
                nap_cnt_q <= 32'(NAP_CYC);
            else if (nap_cnt_q != 32'h0)
                nap_cnt_q <= nap_cnt_q - 32'h1;
        end
    end

    // Output pins, all registered
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            busy_n_q <= 1'b1;
            oe_q     <= 1'b0;
            data_q   <= 12'h000;
            low_q    <= 8'h00;
            conv_q   <= 1'b0;
        end else begin
            busy_n_q <= ~conv_next;
            conv_q   <= conv_next;
            oe_q     <= reading;
            // Previous result shown until finish, then the new one
            data_q   <= shown_word;
            low_q    <= shown_byte;
        end
    end

    assign LINK.busy_n          = busy_n_q;
    assign LINK.reference_ready = reference_ready_q;
    assign LINK.data_oe         = oe_q;
    assign LINK.data_out        = data_q;
    assign LINK.low_data_lines  = low_q;
    assign CONVERTING           = conv_q;
endmodule
`default_nettype wire

//--- verilog/acp_host.sv
// Host end: drives strobes per mode and captures results
`timescale 1ns/100ps
`default_nettype none
`include "acp_params.svh"
module acp_host (
    input  wire logic              MCLK,
    input  wire logic              ARST_N,
    acp_if.host                    LINK,
    input  wire acp_pkg::acp_mode_t MODE,
    input  wire logic              GO,
    input  wire logic              READ_HIGH,
    input  wire logic              SLEEP_REQ,
    input  wire logic              NAP_REQ,
    output logic                   DONE,
    output logic [11:0]            RESULT
);
    // Host sequencer states
    typedef enum logic [1:0] {H_IDLE = 2'b00, H_PULSE = 2'b01, H_WAIT = 2'b11, H_END = 2'b10} acp_hstate_t;
    acp_hstate_t st_q;
    logic        cst_q, rd_q, busy_q, done_q;
    logic [11:0] res_q;

    wire strobe_mode = (MODE == acp_pkg::ACP_SLOW) || (MODE == acp_pkg::ACP_ROM);
    wire busy_rise   = ~busy_q & LINK.busy_n;
    wire ready       = LINK.reference_ready & LINK.busy_n;

    // Sequencer: one convert pulse, one clock wide except in SLOW and ROM, wait busy, capture
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q   <= H_IDLE;
            cst_q  <= 1'b1;
            rd_q   <= 1'b1;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            res_q  <= 12'h000;
        end else begin
            busy_q <= LINK.busy_n;
            done_q <= 1'b0;
            unique case (st_q)
                H_IDLE: if (GO && ready) begin
                    st_q  <= H_PULSE;
                    cst_q <= 1'b0;
                    rd_q  <= ~strobe_mode;
                end
                H_PULSE: begin
                    st_q <= H_WAIT;
                    if (!strobe_mode) cst_q <= 1'b1;
                end
                H_WAIT: if (busy_rise) begin
                    st_q   <= H_END;
                    cst_q  <= 1'b1;
                    rd_q   <= 1'b1;
                    res_q  <= LINK.data_out;
                    done_q <= 1'b1;
                end else if (busy_q && LINK.busy_n) begin
                    // Start refused (nap or sleep): give up, else we would hang
                    st_q  <= H_END;
                    cst_q <= 1'b1;
                    rd_q  <= 1'b1;
                end
                H_END: st_q <= H_IDLE;
            endcase
        end
    end

    assign LINK.cs_n             = 1'b0;
    assign LINK.rd_n             = (MODE == acp_pkg::ACP_M2) ? 1'b1 :
                                   (strobe_mode ? rd_q : 1'b0);
    assign LINK.convert_start_n  = cst_q;
    assign LINK.high_byte_select = READ_HIGH;
    assign LINK.sleep_n          = ~SLEEP_REQ;
    assign LINK.nap_n            = ~NAP_REQ;
    assign DONE                  = done_q;
    assign RESULT                = res_q;
endmodule
`default_nettype wire

//--- test/acp_link_chk.sv
// Timing checker for the converter control link
`timescale 1ns/100ps
`default_nettype none
module acp_link_chk #(parameter int CONV_CYC = 600, parameter int WAKE_CYC = 20) (
    input wire logic        MCLK,
    input wire logic        ARST_N,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        convert_start_n,
    input wire logic        high_byte_select,
    input wire logic        sleep_n,
    input wire logic        nap_n,
    input wire logic        busy_n,
    input wire logic        reference_ready,
    input wire logic [11:0] data_out,
    input wire logic [7:0]  low_data_lines,
    input wire logic        data_oe
);
    int bcnt_q; // Busy low cycles
    int wcnt_q; // Awake but not ready cycles
    // Counters, since long repetitions slow the tools
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bcnt_q <= 32'h0;
            wcnt_q <= 32'h0;
        end else begin
            bcnt_q <= busy_n ? 32'h0 : bcnt_q + 32'h1;
            wcnt_q <= (!sleep_n || reference_ready) ? 32'h0 : wcnt_q + 32'h1;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    a_start_cause: assert property ($fell(busy_n) |->
        $past(!convert_start_n && !cs_n && sleep_n && nap_n)) else $error("busy fell without start");
    a_busy_len: assert property ($rose(busy_n) |-> bcnt_q == CONV_CYC)
        else $error("wrong conversion length");
    a_oe_follow: assert property ($past(ARST_N) |-> data_oe == $past(!cs_n && !rd_n))
        else $error("bus enable wrong");
    a_byte_pick: assert property ($stable(high_byte_select) && $stable(data_out) |->
        low_data_lines == (high_byte_select ? {4'h0, data_out[11:8]} : data_out[7:0])) else $error("byte wrong");
    a_data_hold: assert property ($changed(data_out) |-> $rose(busy_n))
        else $error("data moved outside finish");
    a_sleep_drop: assert property (!sleep_n |=> !reference_ready)
        else $error("ready high in sleep");
    a_wake_min: assert property ($rose(reference_ready) |-> wcnt_q >= WAKE_CYC - 1)
        else $error("wake too short");
    a_wake_max: assert property (wcnt_q <= WAKE_CYC + 1)
        else $error("wake too long");
endmodule
`default_nettype wire

//--- test/adc_conversion_control_port_bench.sv
// Bench joining converter and host back to back
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control_port_bench;
    localparam int CONV = 600; // Conversion cycles
    localparam int WAKE = 20;  // Shortened wake keeps the run brief
    logic               mclk = 1'b0;
    logic               arst_n = 1'b0;
    acp_pkg::acp_mode_t mode = acp_pkg::ACP_M1A;
    logic               go = 1'b0;
    logic               read_high = 1'b0;
    logic               sleep_req = 1'b0;
    logic               nap_req = 1'b0;
    logic [11:0]        sample = 12'h000; // Analog stand-in
    logic [11:0]        prev = 12'h000;   // Last converted value
    logic               done;
    logic [11:0]        result;
    logic [31:0]        seed = 32'hba9f;
    int                 fails = 0;
    int                 num_checks = 0;
    acp_if acp_if_i ();
    always #5 mclk = ~mclk;
    acp_device #(.CONV_CYC(CONV), .WAKE_CYC(WAKE)) acp_device_i (.MCLK(mclk), .ARST_N(arst_n), .LINK(acp_if_i),
        .SAMPLE(sample), .CONVERTING());
    acp_host acp_host_i (.MCLK(mclk), .ARST_N(arst_n), .LINK(acp_if_i), .MODE(mode), .GO(go), .READ_HIGH(read_high),
        .SLEEP_REQ(sleep_req), .NAP_REQ(nap_req), .DONE(done), .RESULT(result));
    acp_link_chk #(.CONV_CYC(CONV), .WAKE_CYC(WAKE)) acp_link_chk_i (.MCLK(mclk), .ARST_N(arst_n),
        .cs_n(acp_if_i.cs_n), .rd_n(acp_if_i.rd_n), .convert_start_n(acp_if_i.convert_start_n),
        .high_byte_select(acp_if_i.high_byte_select), .sleep_n(acp_if_i.sleep_n), .nap_n(acp_if_i.nap_n),
        .busy_n(acp_if_i.busy_n), .reference_ready(acp_if_i.reference_ready), .data_out(acp_if_i.data_out),
        .low_data_lines(acp_if_i.low_data_lines), .data_oe(acp_if_i.data_oe));
    // Xorshift source, fixed seed
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One conversion; done follows the busy rise by a cycle, so wait for done and busy high
    task automatic convert(input acp_pkg::acp_mode_t m);
        int n, nb;
        logic seen;
        n = 0;
        nb = 0;
        seen = 1'b0;
        @(posedge mclk);
        #1;
        mode = m;
        sample = 12'(rnd());
        read_high = ^rnd();
        go = 1'b1;
        while (!(seen && acp_if_i.busy_n === 1'b1) && n < 2000) begin
            @(posedge mclk);
            #1;
            n++;
            seen = seen | (done === 1'b1);
            if (acp_if_i.busy_n === 1'b0) nb++;
            if (acp_if_i.busy_n === 1'b0) chk(acp_if_i.data_out, prev);
        end
        go = 1'b0;
        chk({11'h0, n >= 2000}, 12'h000);
        chk(12'(nb), 12'(CONV));
        chk(acp_if_i.data_out, sample);
        chk({4'h0, acp_if_i.low_data_lines}, read_high ? {8'h0, sample[11:8]} : {4'h0, sample[7:0]});
        if (m != acp_pkg::ACP_ROM) chk(result, sample);
        prev = sample;
    endtask
    // Power-down with a request held; sample kept so a late start converts the same value
    task automatic power(input logic sl);
        int nb;
        nb = 0;
        sleep_req = sl;
        nap_req = ~sl;
        repeat (3) @(posedge mclk);
        #1 go = 1'b1;
        repeat (30) begin
            @(posedge mclk);
            #1;
            if (acp_if_i.busy_n !== 1'b1) nb++;
        end
        chk(12'(nb), 12'h000);
        go = 1'b0;
        sleep_req = 1'b0;
        nap_req = 1'b0;
        repeat (WAKE / 2) @(posedge mclk);
        #1;
        if (sl) chk({11'h0, acp_if_i.reference_ready}, 12'h000);
        repeat (700) @(posedge mclk);
        #1 chk({11'h0, acp_if_i.reference_ready}, 12'h001);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog
    initial begin
        #200000;
        fails++;
        $display("[ERR] %0t got %h exp %h", $time, 32'h0, 32'h1);
        complete_run;
    end
    // Main sequence: every mode, then random modes around power-downs
    initial begin
        repeat (2) @(posedge mclk);
        #1 arst_n = 1'b1;
        for (int t = 0; t < 10; t++) begin
            if (t == 5) power(1'b1);
            if (t == 7) power(1'b0);
            convert(t < 5 ? acp_pkg::acp_mode_t'(3'(t)) : acp_pkg::acp_mode_t'(3'(rnd() % 5)));
            $display("test %0d done", t);
        end
        complete_run;
    end
endmodule
`default_nettype wire
